// file: verilog/ebp_map.svh
// constants for the expansion bus pin control block
// assumes inclusion by the top level design file and by the bench
`ifndef EBP_MAP_SVH
`define EBP_MAP_SVH
`define EBP_OFF_ASSIGN 32'h0000_0000
`define EBP_OFF_PORT_A 32'h0000_0004
`define EBP_OFF_PORT_B 32'h0000_0008
`define EBP_OFF_DDR_A 32'h0000_000C
`define EBP_OFF_DDR_B 32'h0000_0010
`define EBP_OFF_CMD 32'h0000_0014
`define EBP_OFF_STATUS 32'h0000_0018
`define EBP_OFF_TRACK 32'h0000_001C
`define EBP_BIT_RW_EN 0
`define EBP_BIT_LS_EN 1
`define EBP_BIT_CLK_EN 2
`define EBP_BIT_DBE_EN 3
`define EBP_BIT_PIPE_EN 4
`define EBP_BIT_STOP 5
`define EBP_STR_LSB 8
`define EBP_STR_W 2
`define EBP_BIT_GO 0
`define EBP_BIT_WR 1
`define EBP_BIT_SZ8 2
`define EBP_BIT_BUSY 0
`define EBP_RST_DDR 8'h00
`define EBP_CLK_DIV 2
`endif

// file: verilog/ebp_pkg.sv
// types for the expansion bus pin control block
// assumes nothing beyond the constants header
package ebp_pkg;
    typedef enum logic [2:0] {
        EBP_NORMAL_SINGLE,
        EBP_NORMAL_EXP_NARROW,
        EBP_NORMAL_EXP_WIDE,
        EBP_SPECIAL_SINGLE,
        EBP_SPECIAL_EXP_NARROW,
        EBP_SPECIAL_EXP_WIDE,
        EBP_SPECIAL_PERIPH,
        EBP_NORMAL_RESERVED
    } ebp_mode_type;
    typedef enum logic [1:0] {
        EBP_IDLE,
        EBP_ADDR,
        EBP_DATA,
        EBP_STRETCH
    } ebp_phase_type;
endpackage

// file: verilog/ebp_sync.sv
// two flip-flop synchroniser for pin inputs, one per bit
// assumes clk is the only clock; pins are asynchronous
`timescale 1ns/1ns
`default_nettype none
module ebp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [WIDTH-1:0] pin_in, // raw pin levels
    output logic [WIDTH-1:0] pin_sync // synchronised levels
);
    logic [WIDTH-1:0] stage1;
    // first stage is read by the second stage only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            pin_sync <= '0;
        end else begin
            stage1 <= pin_in;
            pin_sync <= stage1;
        end
    end
endmodule
`default_nettype wire

// file: verilog/ebp_ahb_slave.sv
// ahb-lite slave front end, one wait-free word register port
// assumes single word transfers; answers OKAY always
`timescale 1ns/1ns
`default_nettype none
module ebp_ahb_slave (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic hready, // bus ready in
    output logic hreadyout, // slave ready
    output logic [7:0] wr_addr, // write word offset
    output logic wr_stb, // one-cycle write strobe
    output logic [7:0] rd_addr // read word offset
);
    logic ph_write;
    logic [7:0] ph_addr;
    wire take = hsel && hready && htrans[1];
    // address phase capture; data phase follows one cycle later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_write <= 1'b0;
            ph_addr <= 8'h00;
            hreadyout <= 1'b1;
        end else begin
            ph_write <= take && hwrite;
            if (take) begin
                ph_addr <= haddr[7:0];
            end
            hreadyout <= 1'b1;
        end
    end
    assign wr_addr = ph_addr;
    assign wr_stb = ph_write;
    assign rd_addr = ph_addr;
endmodule
`default_nettype wire

// file: verilog/ebp_top.sv
// expansion bus pin control: mode straps, bus clock, muxed address/data
// assumes one 25 MHz clock, ahb-lite register access, pads outside
// What this block does
// - bus clock runs at half crystal rate
// - normal single-chip: bus clock off after reset
// - special single-chip: bus clock on from reset
// - special peripheral: bus clock pin is input
// - stop mode halts the bus clock
// - bus cycle stretches by whole bus clocks for slow memory
// - single-chip pins are ports, expanded are bus
// - wide: upper/lower ports mux address and data
// - narrow: upper port shares address and data
// - narrow word: high byte then low byte
// - rw pin is pulled input until enabled
// - no external write before rw enabled
// - low strobe pulled input until enabled
// - special expanded: strobe pin is tag input only, never driven
// - mode taken from three pins on the third clock after reset
// - lower mode pins become queue track outputs
// - pulldowns on lower mode pins during reset
// - special select pin becomes debug or tag
// - queue state multiplexed on track outputs
// - low strobe is xnor of a0 and size
// - data enable low only in clock high
//
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "ebp_map.svh"
module ebp_top import ebp_pkg::*; #(
    parameter int STRETCH_W = `EBP_STR_W
) (
    input wire logic clk, // crystal-rate clock
    input wire logic rst_n, // async reset, active low
    input wire logic hsel, // ahb select
    input wire logic [31:0] haddr, // ahb address
    input wire logic [1:0] htrans, // ahb transfer type
    input wire logic hwrite, // ahb write
    input wire logic [2:0] hsize, // ahb size, word only
    input wire logic [31:0] hwdata, // ahb write data
    input wire logic hready, // ahb ready in
    output logic hreadyout, // ahb ready out
    output logic [31:0] hrdata, // ahb read data
    output logic hresp, // ahb response, always okay
    input wire logic special_mode_select_n, // mode pin, also debug
    input wire logic mode_select_a, // mode pin a
    input wire logic mode_select_b, // mode pin b
    input wire logic [1:0] queue_state, // core queue state
    output logic queue_track_0, // track output 0
    output logic queue_track_1, // track output 1
    output logic track_oe, // track outputs enabled
    output logic mode_pulldown, // pulldowns on mode pins
    output logic debug_pin_sel, // select pin in debug role
    output logic tag_high_input, // high tag seen
    output logic tag_low_input, // low tag seen
    input wire logic bus_clk_in, // bus clock pin level
    output logic bus_phase_clock, // bus clock pin drive
    output logic bus_clk_oe, // bus clock pin enable
    output logic [7:0] upper_port_out, // upper port drive
    output logic [7:0] upper_port_oe, // upper port enables
    input wire logic [7:0] upper_port_pins, // upper port level
    output logic [7:0] lower_port_out, // lower port drive
    output logic [7:0] lower_port_oe, // lower port enables
    input wire logic [7:0] lower_port_pins, // lower port level
    output logic rw_out, // rw pin drive
    output logic rw_oe, // rw pin enable
    output logic rw_pullup, // rw pin pullup on
    input wire logic rw_pin, // rw pin level
    output logic low_byte_strobe, // strobe pin drive
    output logic strobe_oe, // strobe pin enable
    output logic strobe_pullup, // strobe pin pullup on
    input wire logic strobe_pin, // strobe pin level
    output logic data_bus_enable_n // data enable, active low
);
    // pin synchronisers
    logic [2:0] mode_sync;
    logic [7:0] up_sync;
    logic [7:0] lo_sync;
    logic [2:0] misc_sync;
    ebp_sync #(.WIDTH(3)) u_sync_mode (.clk(clk), .rst_n(rst_n),
        .pin_in({special_mode_select_n, mode_select_b, mode_select_a}), .pin_sync(mode_sync));
    ebp_sync #(.WIDTH(8)) u_sync_up (.clk(clk), .rst_n(rst_n), .pin_in(upper_port_pins), .pin_sync(up_sync));
    ebp_sync #(.WIDTH(8)) u_sync_lo (.clk(clk), .rst_n(rst_n), .pin_in(lower_port_pins), .pin_sync(lo_sync));
    ebp_sync #(.WIDTH(3)) u_sync_misc (.clk(clk), .rst_n(rst_n),
        .pin_in({bus_clk_in, strobe_pin, rw_pin}), .pin_sync(misc_sync));

    // bus slave
    logic [7:0] wr_addr;
    logic wr_stb;
    logic [7:0] rd_addr;
    ebp_ahb_slave u_ahb (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .wr_addr(wr_addr), .wr_stb(wr_stb),
        .rd_addr(rd_addr));

    // mode strap: the synchroniser is cleared by reset, so wait until it holds the pins
    ebp_mode_type mode;
    logic strap_done;
    logic [1:0] strap_cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_done <= 1'b0;
            strap_cnt <= 2'h0;
            mode <= EBP_NORMAL_SINGLE;
        end else if (!strap_done) begin
            if (strap_cnt == 2'h2) begin
                strap_done <= 1'b1;
                mode <= ebp_mode_type'(mode_sync);
            end else begin
                strap_cnt <= strap_cnt + 2'h1;
            end
        end
    end
    wire special_m = (mode == EBP_SPECIAL_SINGLE) || (mode == EBP_SPECIAL_EXP_NARROW) ||
        (mode == EBP_SPECIAL_EXP_WIDE) || (mode == EBP_SPECIAL_PERIPH);
    wire single_m = (mode == EBP_NORMAL_SINGLE) || (mode == EBP_SPECIAL_SINGLE);
    wire narrow_m = (mode == EBP_NORMAL_EXP_NARROW) || (mode == EBP_SPECIAL_EXP_NARROW);
    wire periph_m = (mode == EBP_SPECIAL_PERIPH);
    wire expanded_m = !single_m && !periph_m && strap_done;
    wire spec_exp_m = (mode == EBP_SPECIAL_EXP_NARROW) || (mode == EBP_SPECIAL_EXP_WIDE);

    // assign register: enables, stretch, stop
    logic [15:0] assign_reg;
    logic [7:0] port_a, port_b, ddr_a, ddr_b;
    logic [15:0] xfer_addr, xfer_data;
    logic [2:0] cmd;
    logic go;
    wire wr_assign = wr_stb && (wr_addr == `EBP_OFF_ASSIGN);
    // clock enable default follows mode once the strap is known
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            assign_reg <= 16'h0000;
        end else if (strap_done == 1'b0) begin
            assign_reg <= 16'h0000;
        end else if (wr_assign) begin
            assign_reg <= hwdata[15:0] | 16'h8000; // a write must not be undone by the defaults
        end else if (assign_reg[15]) begin
            assign_reg <= assign_reg;
        end else begin
            // first cycle after strap: load mode defaults
            assign_reg[15] <= 1'b1;
            assign_reg[`EBP_BIT_CLK_EN] <= !(mode == EBP_NORMAL_SINGLE);
            assign_reg[`EBP_BIT_DBE_EN] <= expanded_m;
        end
    end
    wire rw_en = assign_reg[`EBP_BIT_RW_EN];
    wire ls_en = assign_reg[`EBP_BIT_LS_EN];
    wire clk_en = assign_reg[`EBP_BIT_CLK_EN];
    wire dbe_en = assign_reg[`EBP_BIT_DBE_EN];
    wire pipe_en = assign_reg[`EBP_BIT_PIPE_EN];
    wire stop_m = assign_reg[`EBP_BIT_STOP];
    wire [STRETCH_W-1:0] stretch = assign_reg[`EBP_STR_LSB +: STRETCH_W];

    // port and transfer registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_a <= 8'h00;
            port_b <= 8'h00;
            ddr_a <= `EBP_RST_DDR;
            ddr_b <= `EBP_RST_DDR;
            xfer_addr <= 16'h0000;
            xfer_data <= 16'h0000;
            cmd <= 3'h0;
        end else if (wr_stb) begin
            if (wr_addr == `EBP_OFF_PORT_A) port_a <= hwdata[7:0];
            if (wr_addr == `EBP_OFF_PORT_B) port_b <= hwdata[7:0];
            if (wr_addr == `EBP_OFF_DDR_A) ddr_a <= hwdata[7:0];
            if (wr_addr == `EBP_OFF_DDR_B) ddr_b <= hwdata[7:0];
            if (wr_addr == `EBP_OFF_CMD) begin
                cmd <= hwdata[2:0];
                xfer_addr <= hwdata[31:16];
            end
            if (wr_addr == `EBP_OFF_TRACK) xfer_data <= hwdata[15:0];
        end
    end
    assign go = wr_stb && (wr_addr == `EBP_OFF_CMD) && hwdata[`EBP_BIT_GO];

    // half-rate bus clock as enable; stop freezes it
    logic eph;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eph <= 1'b0;
        end else if (!stop_m) begin
            eph <= !eph;
        end
    end
    wire e_rise = !eph && !stop_m; // eph goes high next edge

    // bus cycle sequencer: address in low phase, data in high phase
    ebp_phase_type phase;
    logic [STRETCH_W-1:0] st_cnt;
    logic second_byte;
    logic [15:0] rd_capture;
    logic busy;
    wire want_write = cmd[`EBP_BIT_WR] && rw_en;
    wire sz8 = cmd[`EBP_BIT_SZ8];
    wire low_wr_blocked = want_write && !ls_en && !sz8 && !narrow_m;
    // pins lag the phase by one output flop and two sync flops: capture three edges late
    logic [2:0][2:0] cap_q;
    wire cap_now = (phase == EBP_DATA) && eph && !stop_m;
    wire more = narrow_m && !sz8 && !second_byte;
    wire [2:0] cap = cap_q[2];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= EBP_IDLE;
            st_cnt <= '0;
            second_byte <= 1'b0;
            rd_capture <= 16'h0000;
            busy <= 1'b0;
            cap_q <= '0;
        end else begin
            cap_q <= {cap_q[1:0], {cap_now, second_byte, !more}};
            if (cap[2]) begin
                if (narrow_m && !cap[1]) begin
                    rd_capture[15:8] <= up_sync;
                end else if (narrow_m) begin
                    rd_capture[7:0] <= up_sync;
                end else begin
                    rd_capture <= {up_sync, lo_sync};
                end
                if (cap[0]) busy <= 1'b0;
            end
            unique case (phase)
                EBP_IDLE: begin
                    if (go && expanded_m) begin
                        busy <= 1'b1;
                        second_byte <= 1'b0;
                        phase <= EBP_ADDR;
                    end
                end
                EBP_ADDR: begin
                    if (e_rise) begin
                        st_cnt <= stretch;
                        phase <= (stretch != '0) ? EBP_STRETCH : EBP_DATA;
                    end
                end
                EBP_STRETCH: begin
                    if (e_rise) begin
                        st_cnt <= st_cnt - 1'b1;
                        if (st_cnt == {{(STRETCH_W-1){1'b0}}, 1'b1}) phase <= EBP_DATA;
                    end
                end
                EBP_DATA: begin
                    if (cap_now) begin
                        if (more) begin
                            second_byte <= 1'b1;
                            phase <= EBP_ADDR;
                        end else begin
                            phase <= EBP_IDLE;
                        end
                    end
                end
            endcase
        end
    end
    wire in_data = (phase == EBP_DATA);
    wire bus_act = (phase != EBP_IDLE);
    wire drive_wr = bus_act && in_data && want_write && !low_wr_blocked;
    wire [15:0] cur_addr = xfer_addr + {15'h0000, second_byte};
    wire a0 = cur_addr[0];
    wire [7:0] narrow_data = second_byte ? xfer_data[7:0] : xfer_data[15:8];

    // pin multiplexing
    wire [7:0] next_up = !expanded_m ? port_a :
        (in_data ? (narrow_m ? narrow_data : xfer_data[15:8]) : cur_addr[15:8]);
    wire [7:0] next_lo = !expanded_m ? port_b :
        (in_data && !narrow_m ? xfer_data[7:0] : cur_addr[7:0]);
    wire data_out_phase = in_data && !want_write;
    wire [7:0] next_up_oe = !expanded_m ? ddr_a : (data_out_phase ? 8'h00 : 8'hFF);
    wire [7:0] next_lo_oe = !expanded_m ? ddr_b :
        ((data_out_phase && !narrow_m) ? 8'h00 : 8'hFF);
    wire next_strobe = !(a0 ^ sz8);
    wire strobe_act = ls_en && !spec_exp_m ? 1'b1 : (ls_en && spec_exp_m);
    wire next_dbe_n = !(dbe_en && expanded_m && eph && !stop_m && in_data);
    wire next_clk_oe = clk_en && !periph_m;
    wire [1:0] next_track = eph ? {queue_state[1], queue_state[0]} : {queue_state[0], queue_state[1]};

    // registered pin outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upper_port_out <= 8'h00;
            upper_port_oe <= 8'h00;
            lower_port_out <= 8'h00;
            lower_port_oe <= 8'h00;
            bus_phase_clock <= 1'b0;
            bus_clk_oe <= 1'b0;
            rw_out <= 1'b1;
            rw_oe <= 1'b0;
            rw_pullup <= 1'b1;
            low_byte_strobe <= 1'b1;
            strobe_oe <= 1'b0;
            strobe_pullup <= 1'b1;
            data_bus_enable_n <= 1'b1;
            queue_track_0 <= 1'b0;
            queue_track_1 <= 1'b0;
            track_oe <= 1'b0;
            mode_pulldown <= 1'b1;
            debug_pin_sel <= 1'b0;
            tag_high_input <= 1'b0;
            tag_low_input <= 1'b0;
        end else begin
            upper_port_out <= next_up;
            upper_port_oe <= next_up_oe;
            lower_port_out <= next_lo;
            lower_port_oe <= next_lo_oe;
            bus_phase_clock <= eph && !stop_m;
            bus_clk_oe <= next_clk_oe && !stop_m;
            rw_out <= !drive_wr;
            rw_oe <= rw_en;
            rw_pullup <= !rw_en;
            low_byte_strobe <= next_strobe;
            strobe_oe <= strobe_act && !spec_exp_m;
            strobe_pullup <= !ls_en;
            data_bus_enable_n <= next_dbe_n;
            queue_track_0 <= next_track[0];
            queue_track_1 <= next_track[1];
            track_oe <= pipe_en && strap_done;
            mode_pulldown <= !strap_done;
            debug_pin_sel <= strap_done && special_m;
            tag_high_input <= strap_done && special_m && !mode_sync[2];
            tag_low_input <= spec_exp_m && ls_en && !misc_sync[1];
        end
    end

    // read mux and bus answer
    wire [31:0] rd_val =
        (rd_addr == `EBP_OFF_ASSIGN) ? {16'h0000, assign_reg} :
        (rd_addr == `EBP_OFF_PORT_A) ? {24'h000000, up_sync} :
        (rd_addr == `EBP_OFF_PORT_B) ? {24'h000000, lo_sync} :
        (rd_addr == `EBP_OFF_DDR_A) ? {24'h000000, ddr_a} :
        (rd_addr == `EBP_OFF_DDR_B) ? {24'h000000, ddr_b} :
        (rd_addr == `EBP_OFF_CMD) ? {xfer_addr, 13'h0000, cmd} :
        (rd_addr == `EBP_OFF_STATUS) ? {rd_capture, 5'h00, misc_sync, 1'b0, mode, 3'h0, busy} :
        (rd_addr == `EBP_OFF_TRACK) ? {16'h0000, xfer_data} : 32'h00000000;
    assign hrdata = rd_val;
    assign hresp = 1'b0;

    // assertions
    property p_dbe_high_phase;
        @(posedge clk) disable iff (!rst_n) !data_bus_enable_n |-> $past(eph);
    endproperty
    a_dbe_high_phase: assert property (p_dbe_high_phase) else $error("data enable outside clock high");
    property p_read_high;
        @(posedge clk) disable iff (!rst_n) !want_write |=> rw_out;
    endproperty
    a_read_high: assert property (p_read_high) else $error("rw pin low on read");
    property p_no_write_disabled;
        @(posedge clk) disable iff (!rst_n) !rw_en |=> rw_out;
    endproperty
    a_no_write_disabled: assert property (p_no_write_disabled) else $error("write without rw enable");
    property p_clk_toggle;
        @(posedge clk) disable iff (!rst_n) !stop_m ##1 !stop_m |-> eph != $past(eph);
    endproperty
    a_clk_toggle: assert property (p_clk_toggle) else $error("bus clock not half rate");
    property p_periph_input;
        @(posedge clk) disable iff (!rst_n) periph_m |=> !bus_clk_oe;
    endproperty
    a_periph_input: assert property (p_periph_input) else $error("bus clock driven in peripheral mode");
    property p_stop_halt;
        @(posedge clk) disable iff (!rst_n) stop_m |=> !bus_phase_clock;
    endproperty
    a_stop_halt: assert property (p_stop_halt) else $error("bus clock running in stop");
    property p_pulldown;
        @(posedge clk) disable iff (!rst_n) !strap_done |=> mode_pulldown;
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("pulldown missing during strap");
    property p_single_ports;
        @(posedge clk) disable iff (!rst_n) (strap_done && single_m) ##1 single_m |-> upper_port_oe == $past(ddr_a);
    endproperty
    a_single_ports: assert property (p_single_ports) else $error("port not general purpose");
    property p_rw_pull;
        @(posedge clk) disable iff (!rst_n) !rw_en |=> rw_pullup && !rw_oe;
    endproperty
    a_rw_pull: assert property (p_rw_pull) else $error("rw pin not pulled input");
    c_narrow: cover property (@(posedge clk) disable iff (!rst_n) second_byte && in_data);
    c_stretch: cover property (@(posedge clk) disable iff (!rst_n) phase == EBP_STRETCH);
    c_write: cover property (@(posedge clk) disable iff (!rst_n) !rw_out);
endmodule
`default_nettype wire

// file: verif/ebp_mem_model.sv
// external memory model on the multiplexed expansion bus
// assumes pin levels resolved by the bench, one clk per bus clock phase
`timescale 1ns/1ns
`default_nettype none
module ebp_mem_model (
    input wire logic clk, // system clock
    input wire logic bclk, // bus clock level
    input wire logic [7:0] up, // upper port drive
    input wire logic [7:0] lo, // lower port drive
    input wire logic wr_n, // rw pin level
    input wire logic ls_n, // strobe pin level
    input wire logic dbe_n, // data enable level
    output logic [7:0] up_drv, // upper port answer
    output logic [7:0] lo_drv, // lower port answer
    output logic ext_clk // supplied bus clock
);
    logic bclk_q = 1'b0;
    logic wr_seen = 1'b0;
    logic [15:0] a_lat = 16'h0000;
    logic [16:0] d_cap = 17'h00000;
    logic [15:0] w_addr [0:1];
    logic [16:0] w_data [0:1];
    int wr_count = 0;
    // outside party supplies the clock in peripheral mode
    initial begin
        ext_clk = 1'b0;
        forever #40 ext_clk = ~ext_clk;
    end
    // answer only while data enable is low, else a changing pattern
    assign up_drv = dbe_n ? ~up : 8'hC3;
    assign lo_drv = dbe_n ? ~lo : 8'h3C;
    // latch stays open while the bus clock is low, closes at its rise
    always @(posedge clk) begin
        bclk_q <= bclk;
        if (!bclk)
            a_lat <= {up, lo};
        if (bclk && !wr_n) begin
            wr_seen <= 1'b1;
            d_cap <= {ls_n, up, lo};
        end
        // log one write per bus cycle at the falling edge
        if (bclk_q && !bclk && wr_seen) begin
            // newest write in entry 0, the one before in entry 1
            w_addr[1] <= w_addr[0];
            w_data[1] <= w_data[0];
            w_addr[0] <= a_lat;
            w_data[0] <= d_cap;
            wr_count <= wr_count + 1;
            wr_seen <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: verif/test_external_bus_pin_control.sv
// self-checking bench for the expansion bus pin control block
// assumes the memory model stands on the port pins
`timescale 1ns/1ns
`default_nettype none
`include "ebp_map.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_external_bus_pin_control import ebp_pkg::*; ;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic special_mode_select_n = 1'b0, mode_select_a = 1'b0, mode_select_b = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0, queue_state = 2'h2;
    logic [2:0] hsize = 3'h2;
    logic queue_track_0, queue_track_1, track_oe, mode_pulldown, debug_pin_sel, tag_high_input;
    logic tag_low_input, bus_phase_clock, bus_clk_oe, rw_out, rw_oe, rw_pullup;
    logic low_byte_strobe, strobe_oe, strobe_pullup, data_bus_enable_n, ext_clk;
    logic [7:0] upper_port_out, upper_port_oe, lower_port_out, lower_port_oe, up_drv, lo_drv;
    wire logic hready = hreadyout;
    wire logic bus_clk_in = bus_clk_oe ? bus_phase_clock : ext_clk;
    wire logic rw_pin = rw_oe ? rw_out : 1'b1;
    wire logic strobe_pin = strobe_oe ? low_byte_strobe : 1'b1;
    wire logic [7:0] upper_port_pins = (upper_port_out & upper_port_oe) | (up_drv & ~upper_port_oe);
    wire logic [7:0] lower_port_pins = (lower_port_out & lower_port_oe) | (lo_drv & ~lower_port_oe);
    int n_fail = 0;
    int check_count = 0;
    ebp_top dut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
        .hrdata, .hresp, .special_mode_select_n, .mode_select_a, .mode_select_b, .queue_state,
        .queue_track_0, .queue_track_1, .track_oe, .mode_pulldown, .debug_pin_sel, .tag_high_input,
        .tag_low_input, .bus_clk_in, .bus_phase_clock, .bus_clk_oe, .upper_port_out, .upper_port_oe,
        .upper_port_pins, .lower_port_out, .lower_port_oe, .lower_port_pins, .rw_out, .rw_oe,
        .rw_pullup, .rw_pin, .low_byte_strobe, .strobe_oe, .strobe_pullup, .strobe_pin,
        .data_bus_enable_n);
    ebp_mem_model mem (.clk, .bclk(bus_phase_clock), .up(upper_port_out), .lo(lower_port_out),
        .wr_n(rw_pin), .ls_n(strobe_pin), .dbe_n(data_bus_enable_n), .up_drv, .lo_drv, .ext_clk);
    // 25 MHz system clock
    initial begin
        forever #20 clk = ~clk;
    end
    // one single ahb-lite word transfer; ready sampled just before each edge
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        logic rdy;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        hsel <= 1'b1;
        do begin @(negedge clk); rdy = hreadyout; @(posedge clk); end while (rdy !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(negedge clk); rdy = hreadyout; r = hrdata; @(posedge clk); end while (rdy !== 1'b1);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask
    // poll status until the external cycle is over, bounded
    task automatic wait_idle(output logic [31:0] r);
        int n;
        n = 0;
        do begin bus(`EBP_OFF_STATUS, 1'b0, 32'h0, r); n++; end while (r[`EBP_BIT_BUSY] !== 1'b0 && n < 200);
        if (n >= 200) n_fail++;
    endtask
    // reset with straps held, pin state judged while reset is low
    task automatic do_reset(input ebp_mode_type m);
        logic [31:0] r;
        {special_mode_select_n, mode_select_b, mode_select_a} <= m;
        rst_n <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        `CHK({upper_port_oe, lower_port_oe, rw_oe, strobe_oe, bus_clk_oe}, 19'h0)
        `CHK({rw_pullup, strobe_pullup, data_bus_enable_n, mode_pulldown}, 4'hF)
        @(posedge clk) rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        bus(`EBP_OFF_STATUS, 1'b0, 32'h0, r);
        `CHK(r[6:4], m)
    endtask
    task automatic t_single;
        logic b;
        logic [31:0] r;
        do_reset(EBP_NORMAL_SINGLE);
        `CHK(bus_clk_oe, 1'b0)
        wr(`EBP_OFF_ASSIGN, 32'h1 << `EBP_BIT_CLK_EN);
        @(negedge clk) b = bus_phase_clock;
        @(negedge clk);
        `CHK({bus_clk_oe, bus_phase_clock}, {1'b1, ~b})
        wr(`EBP_OFF_ASSIGN, (32'h1 << `EBP_BIT_CLK_EN) | (32'h1 << `EBP_BIT_STOP));
        repeat (2) @(negedge clk);
        b = bus_phase_clock;
        repeat (3) @(negedge clk);
        `CHK(bus_phase_clock, b)
        wr(`EBP_OFF_DDR_A, 32'hFF);
        wr(`EBP_OFF_PORT_A, 32'h5A);
        wr(`EBP_OFF_ASSIGN, 32'h1 << `EBP_BIT_PIPE_EN);
        bus(`EBP_OFF_PORT_A, 1'b0, 32'h0, r);
        `CHK({upper_port_oe, upper_port_out, r[7:0], track_oe}, 25'h1FEB4B5)
    endtask
    // special single-chip drives the clock, peripheral mode never does
    task automatic t_special;
        do_reset(EBP_SPECIAL_SINGLE);
        `CHK(bus_clk_oe, 1'b1)
        wr(`EBP_OFF_ASSIGN, 32'h0);
        repeat (2) @(negedge clk);
        `CHK(bus_clk_oe, 1'b0)
        do_reset(EBP_SPECIAL_PERIPH);
        wr(`EBP_OFF_ASSIGN, 32'h1 << `EBP_BIT_CLK_EN);
        repeat (2) @(negedge clk);
        `CHK(bus_clk_oe, 1'b0)
    endtask
    // word write before and after rw enable, then a read in wide mode
    task automatic t_exp(input ebp_mode_type m, input logic wide);
        logic [31:0] r;
        int c0;
        do_reset(m);
        c0 = mem.wr_count;
        wr(`EBP_OFF_TRACK, 32'h1234);
        wr(`EBP_OFF_CMD, 32'hABCD0003);
        wait_idle(r);
        `CHK(mem.wr_count - c0, 0)
        wr(`EBP_OFF_ASSIGN, 32'h0F);
        wr(`EBP_OFF_CMD, 32'hABCD0003);
        wait_idle(r);
        `CHK(mem.w_addr[wide ? 0 : 1], 16'hABCD)
        if (wide) begin
            `CHK({mem.wr_count - c0, mem.w_data[0]}, {32'd1, 17'h01234})
            wr(`EBP_OFF_CMD, 32'hABCD0001);
            wait_idle(r);
            `CHK({mem.wr_count - c0, r[31:16]}, {32'd1, 16'hC33C})
        end else begin
            `CHK({mem.wr_count - c0, mem.w_data[1][15:8], mem.w_data[0][15:8]}, {32'd2, 16'h1234})
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        #400000;
        n_fail++;
        end_of_test();
    end
    initial begin
        @(posedge clk);
        t_single();
        t_special();
        t_exp(EBP_NORMAL_EXP_WIDE, 1'b1);
        t_exp(EBP_NORMAL_EXP_NARROW, 1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire
